// ===== pel_phy_link.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
// Function
// - Append T R after last transmit symbol
// - Check symbol pairs during 100M reception
// - T R ends frame, idles substituted
// - I I ends early, error on nibble
// - Premature end sets bad delimiter status
// - 10M start-of-idle pulse after transmit ends
// - 10M missing transitions end reception
// - 10M link pulses sent, received ones pass
// - 100M link from squelch and lock
// - Exchange 16-bit words via pulse bursts
// - Start on enable, link fail, restart
// - Parallel detect plain 10M/100M partner
// - Advertise register, store partner word
// - Priority resolution of common abilities
// - Report negotiated speed and duplex
// - Done flag after start and completion
// - Negotiate only with both enables set
// - Quiet 1200 ms, then fail, renegotiate
// - Fallback speed/duplex from MAC or PHY bits
// - Link disable forces pass, keeps pulses
// - 10M jabber idles, collides, sets status
module pel_phy_link
  import pel_pkg::*;
#(
  parameter int HALT_CYCLES   = pel_pkg::HALT_CYC,
  parameter int PULSE_CYCLES  = pel_pkg::PULSE_CYC,
  parameter int LOSS_CYCLES   = pel_pkg::LOSS_CYC,
  parameter int JABBER_CYCLES = pel_pkg::JABBER_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  input  wire pel_pkg::pel_av_req_type av,
  output logic [31:0]                  av_readdata,
  output logic                         av_waitrequest,
  input  wire logic                    mac_tx_en,
  input  wire logic [3:0]              mac_txd,
  output logic [4:0]                   tx_sym,
  output logic                         tx10_en,
  output logic                         tx_line_en,
  output logic                         start_of_idle_pulse,
  output logic                         normal_link_pulse,
  output logic                         fast_link_pulse_burst,
  output logic [15:0]                  flp_tx_word,
  output logic                         mac_col,
  input  wire logic [4:0]              rx_sym,
  input  wire logic                    rx_sym_valid,
  input  wire logic                    rx_stream_start,
  input  wire logic                    rx10_active,
  input  wire logic                    rx10_transition,
  input  wire logic                    rx_nlp,
  input  wire logic                    rx_flp_valid,
  input  wire logic [15:0]             rx_flp_word,
  input  wire logic                    squelch_ok,
  input  wire logic                    descr_locked,
  output pel_pkg::pel_mii_rx_type      mac_rx,
  output logic                         link_pass,
  output logic                         speed_100,
  output logic                         full_duplex
);
  import pel_pkg::*;

  localparam logic [3:0] SOI_LOAD  = 4'(SOI_CYC);
  localparam logic [3:0] RXQ_LAST  = 4'(RX_SOI_CYC - 1);
  localparam logic [1:0] LINK_CNT  = 2'(LINK_PULSES);

  function automatic logic [4:0] enc(input logic [3:0] n);
    case (n)
      4'h0: enc = 5'h1e;  4'h1: enc = 5'h09;  4'h2: enc = 5'h14;  4'h3: enc = 5'h15;
      4'h4: enc = 5'h0a;  4'h5: enc = 5'h0b;  4'h6: enc = 5'h0e;  4'h7: enc = 5'h0f;
      4'h8: enc = 5'h12;  4'h9: enc = 5'h13;  4'ha: enc = 5'h16;  4'hb: enc = 5'h17;
      4'hc: enc = 5'h1a;  4'hd: enc = 5'h1b;  4'he: enc = 5'h1c;  default: enc = 5'h1d;
    endcase
  endfunction : enc

  function automatic logic [3:0] dec(input logic [4:0] s);
    dec = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (enc(4'(i)) == s) begin
        dec = 4'(i);
      end
    end
  endfunction : dec

  // ==========================================================
  // Register bus
  logic [15:0]          ctrl_q, adv_q, remote_q;
  logic                 ack_q, restart_q, bad_esd_q, jab_st_q, done_q;
  logic [31:0]          rdata_q, rd_mux;
  logic [STAT_W-1:0]    stat;
  logic                 link_q, jab_q, spd_q, dup_q;
  logic                 req, wr_en, wr_stat, set_bad_esd;

  assign req            = av.read | av.write;
  assign av_waitrequest = req & ~ack_q;
  assign wr_en          = av.write & ack_q;
  assign wr_stat        = wr_en & (av.address == OFS_STAT);
  assign av_readdata    = rdata_q;

  always_comb begin
    stat = '0;
    stat[SB_LINK]    = link_q;
    stat[SB_SPEED]   = spd_q;
    stat[SB_DUPLEX]  = dup_q;
    stat[SB_DONE]    = done_q;
    stat[SB_BAD_ESD] = bad_esd_q;
    stat[SB_JABBER]  = jab_st_q;
    stat[SB_JAB_NOW] = jab_q;
    case (av.address)
      OFS_CTRL:   rd_mux = {16'h0000, ctrl_q};
      OFS_ADV:    rd_mux = {16'h0000, adv_q};
      OFS_REMOTE: rd_mux = {16'h0000, remote_q};
      OFS_STAT:   rd_mux = {25'h0000000, stat};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h00000000;
      ctrl_q    <= CTRL_RESET;
      adv_q     <= ADV_RESET;
      restart_q <= 1'b0;
    end else if (ce) begin
      ack_q     <= req & ~ack_q;
      restart_q <= 1'b0;
      if (av.read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_en && av.address == OFS_CTRL) begin
        ctrl_q             <= av.writedata[15:0];
        ctrl_q[CB_RESTART] <= 1'b0;
        restart_q          <= av.writedata[CB_RESTART];
      end
      if (wr_en && av.address == OFS_ADV) begin
        adv_q <= av.writedata[15:0];
      end
    end
  end

  // ==========================================================
  // Mode selection
  logic mac_neg, phy_neg, link_dis, jab_dis, an_en, spd100, dup;
  logic neg_spd_q, neg_dup_q;

  assign mac_neg  = ctrl_q[CB_MAC_NEG];
  assign phy_neg  = ctrl_q[CB_PHY_NEG];
  assign link_dis = ctrl_q[CB_LINK_DIS];
  assign jab_dis  = ctrl_q[CB_JAB_DIS];
  assign an_en    = mac_neg & phy_neg & ~link_dis;

  always_comb begin
    if (link_dis | (mac_neg & ~phy_neg)) begin
      spd100 = ctrl_q[CB_PHY_SPD];
      dup    = ctrl_q[CB_PHY_DUP];
    end else if (~mac_neg) begin
      spd100 = ctrl_q[CB_MAC_SPD];
      dup    = ctrl_q[CB_MAC_DUP];
    end else begin
      spd100 = neg_spd_q;
      dup    = neg_dup_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spd_q <= 1'b0;
      dup_q <= 1'b0;
    end else if (ce) begin
      spd_q <= spd100;
      dup_q <= dup;
    end
  end
  assign speed_100   = spd_q;
  assign full_duplex = dup_q;

  // ==========================================================
  // Negotiation
  pel_an_state_type an_state_q;
  logic an_en_q, link_prev_q, an_start, li_active;
  logic halt_exp, pulse_run, pulse_exp, loss_exp, rx10_seen;
  logic [15:0] common;
  logic detect_ok, res_spd, res_dup, res_ok;

  assign li_active = ~an_en | (an_state_q == AN_DONE);
  assign an_start  = an_en & (~an_en_q | restart_q
                     | (link_prev_q & ~link_q & an_state_q == AN_DONE));
  assign common    = adv_q & rx_flp_word;

  always_comb begin
    res_ok  = 1'b1;
    res_spd = 1'b0;
    res_dup = 1'b0;
    if (common[AB_100F]) begin
      res_spd = 1'b1;
      res_dup = 1'b1;
    end else if (common[AB_100H]) begin
      res_spd = 1'b1;
    end else if (common[AB_10F]) begin
      res_dup = 1'b1;
    end else if (!common[AB_10H]) begin
      res_ok = 1'b0;
    end
  end
  assign detect_ok = (rx_flp_valid & res_ok) | rx_nlp | (squelch_ok & descr_locked);

  pel_timer #(.W(TMR_W), .LOAD(HALT_CYCLES)) u_halt (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .start(an_start), .running(), .expired(halt_exp));
  pel_timer #(.W(TMR_W), .LOAD(PULSE_CYCLES)) u_pulse (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .start(~pulse_run), .running(pulse_run), .expired(pulse_exp));
  pel_timer #(.W(TMR_W), .LOAD(LOSS_CYCLES)) u_loss (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .start(rx10_seen), .running(), .expired(loss_exp));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      an_state_q <= AN_OFF;
    end else if (ce) begin
      if (~an_en) begin
        an_state_q <= AN_OFF;
      end else if (an_start) begin
        an_state_q <= AN_HALT;
      end else begin
        case (an_state_q)
          AN_HALT:   if (halt_exp) an_state_q <= AN_DETECT;
          AN_DETECT: if (detect_ok) an_state_q <= AN_DONE;
          AN_OFF:    an_state_q <= AN_OFF;
          AN_DONE:   an_state_q <= AN_DONE;
          default:   an_state_q <= AN_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      an_en_q   <= 1'b0;
      done_q    <= 1'b0;
      remote_q  <= 16'h0000;
      neg_spd_q <= 1'b0;
      neg_dup_q <= 1'b0;
    end else if (ce) begin
      an_en_q <= an_en;
      if (~an_en | an_start) begin
        done_q <= 1'b0;
      end else if (an_state_q == AN_DETECT && detect_ok) begin
        done_q <= 1'b1;
        if (rx_flp_valid & res_ok) begin
          remote_q  <= rx_flp_word;
          neg_spd_q <= res_spd;
          neg_dup_q <= res_dup;
        end else begin
          neg_spd_q <= ~rx_nlp;
          neg_dup_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Link integrity and pulses
  logic [1:0] nlp_cnt_q;
  logic       nlp_q, flp_q;

  assign rx10_seen = rx_nlp | rx10_active;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q      <= 1'b0;
      link_prev_q <= 1'b0;
      nlp_cnt_q   <= 2'b00;
    end else if (ce) begin
      link_prev_q <= link_q;
      if (~li_active | loss_exp) begin
        nlp_cnt_q <= 2'b00;
      end else if (rx_nlp && nlp_cnt_q != LINK_CNT) begin
        nlp_cnt_q <= nlp_cnt_q + 2'b01;
      end
      if (link_dis) begin
        link_q <= 1'b1;
      end else if (~li_active) begin
        link_q <= 1'b0;
      end else if (spd100) begin
        link_q <= squelch_ok & descr_locked;
      end else if (loss_exp) begin
        link_q <= 1'b0;
      end else if (nlp_cnt_q == LINK_CNT) begin
        link_q <= 1'b1;
      end
    end
  end
  assign link_pass = link_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nlp_q <= 1'b0;
      flp_q <= 1'b0;
    end else if (ce) begin
      nlp_q <= pulse_exp & ~spd100 & li_active & ~mac_tx_en;
      flp_q <= pulse_exp & (an_state_q == AN_DETECT);
    end
  end
  assign normal_link_pulse     = nlp_q;
  assign fast_link_pulse_burst = flp_q;
  assign flp_tx_word           = adv_q;
  assign tx_line_en            = (an_state_q != AN_HALT);

  // ==========================================================
  // Transmit: delimiter, start of idle, jabber
  logic [4:0]       tx_sym_q;
  logic             tx_en_q, r_pend_q, soi_q, tx10_q;
  logic [3:0]       soi_cnt_q;
  logic [TMR_W-1:0] jab_cnt_q;
  logic             jab_act;

  assign jab_act = mac_tx_en & ~spd100 & ~jab_dis;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      jab_cnt_q <= '0;
      jab_q     <= 1'b0;
      jab_st_q  <= 1'b0;
    end else if (ce) begin
      if (~jab_act) begin
        jab_cnt_q <= '0;
        jab_q     <= 1'b0;
      end else if (jab_cnt_q == TMR_W'(JABBER_CYCLES - 1)) begin
        jab_q <= 1'b1;
      end else begin
        jab_cnt_q <= jab_cnt_q + 1'b1;
      end
      jab_st_q <= (jab_act & jab_q) | (jab_st_q & ~(wr_stat & av.writedata[SB_JABBER]));
    end
  end
  assign mac_col = jab_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sym_q <= SYM_I;
      tx_en_q  <= 1'b0;
      r_pend_q <= 1'b0;
      tx10_q   <= 1'b0;
    end else if (ce) begin
      tx_en_q <= mac_tx_en;
      tx10_q  <= mac_tx_en & ~spd100 & ~jab_q & tx_line_en;
      if (~spd100 | ~tx_line_en) begin
        tx_sym_q <= SYM_I;
        r_pend_q <= 1'b0;
      end else if (mac_tx_en) begin
        tx_sym_q <= enc(mac_txd);
        r_pend_q <= 1'b0;
      end else if (tx_en_q) begin
        tx_sym_q <= SYM_T;
        r_pend_q <= 1'b1;
      end else if (r_pend_q) begin
        tx_sym_q <= SYM_R;
        r_pend_q <= 1'b0;
      end else begin
        tx_sym_q <= SYM_I;
      end
    end
  end
  assign tx_sym  = tx_sym_q;
  assign tx10_en = tx10_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soi_cnt_q <= 4'h0;
      soi_q     <= 1'b0;
    end else if (ce) begin
      if (~spd100 & tx_en_q & ~mac_tx_en & ~jab_q & tx_line_en) begin
        soi_cnt_q <= SOI_LOAD;
        soi_q     <= 1'b1;
      end else if (soi_cnt_q != 4'h0) begin
        soi_cnt_q <= soi_cnt_q - 4'h1;
        soi_q     <= (soi_cnt_q != 4'h1);
      end
    end
  end
  assign start_of_idle_pulse = soi_q;

  // ==========================================================
  // Receive: delimiter check and start of idle detection
  logic [4:0]     prev_sym_q;
  logic           rx_in_q, prime_q, rx10_q, rx10_block_q;
  logic [3:0]     quiet_q;
  logic [9:0]     grp;
  logic           chk;
  pel_mii_rx_type mac_rx_q;

  assign grp = {prev_sym_q, rx_sym};
  assign chk = spd100 & rx_sym_valid & rx_in_q & ~prime_q & ~rx_stream_start;
  assign set_bad_esd = chk & (grp == {SYM_I, SYM_I});

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_sym_q <= SYM_I;
      rx_in_q    <= 1'b0;
      prime_q    <= 1'b0;
      bad_esd_q  <= 1'b0;
      mac_rx_q   <= '0;
    end else if (ce) begin
      bad_esd_q <= set_bad_esd | (bad_esd_q & ~(wr_stat & av.writedata[SB_BAD_ESD]));
      if (rx_sym_valid) begin
        prev_sym_q <= rx_sym;
      end
      if (~spd100) begin
        rx_in_q  <= 1'b0;
        mac_rx_q <= '{rxd: 4'h0, dv: rx10_q, er: 1'b0};
      end else if (rx_stream_start) begin
        rx_in_q  <= 1'b1;
        prime_q  <= 1'b1;
        mac_rx_q <= '0;
      end else if (rx_sym_valid & rx_in_q & prime_q) begin
        prime_q <= 1'b0;
      end else if (chk && grp == {SYM_T, SYM_R}) begin
        rx_in_q  <= 1'b0;
        mac_rx_q <= '0;
      end else if (set_bad_esd) begin
        rx_in_q  <= 1'b0;
        mac_rx_q <= '{rxd: 4'h0, dv: 1'b1, er: 1'b1};
      end else if (chk) begin
        mac_rx_q <= '{rxd: dec(prev_sym_q), dv: 1'b1, er: 1'b0};
      end else if (~rx_in_q) begin
        mac_rx_q <= '0;
      end
    end
  end
  assign mac_rx = mac_rx_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx10_q       <= 1'b0;
      rx10_block_q <= 1'b0;
      quiet_q      <= 4'h0;
    end else if (ce) begin
      if (~rx10_active | spd100) begin
        rx10_q       <= 1'b0;
        rx10_block_q <= 1'b0;
        quiet_q      <= 4'h0;
      end else if (~rx10_q & ~rx10_block_q) begin
        rx10_q  <= 1'b1;
        quiet_q <= 4'h0;
      end else if (rx10_q & rx10_transition) begin
        quiet_q <= 4'h0;
      end else if (rx10_q && quiet_q == RXQ_LAST) begin
        rx10_q       <= 1'b0;
        rx10_block_q <= 1'b1;
      end else if (rx10_q) begin
        quiet_q <= quiet_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence s_tr_tail;
    (tx_sym_q == SYM_T) ##1 (tx_sym_q == SYM_R);
  endsequence
  property p_esd;
    (spd100 && tx_line_en && tx_en_q && !mac_tx_en) ##1 (spd100 && !mac_tx_en && tx_line_en) |-> s_tr_tail;
  endproperty
  a_esd: assert property (p_esd) else $error("delimiter pair missing");
  property p_tr_end;
    (chk && grp == {SYM_T, SYM_R}) |=> (!rx_in_q && !mac_rx_q.dv && !mac_rx_q.er);
  endproperty
  a_tr_end: assert property (p_tr_end) else $error("frame not ended on delimiter");
  property p_bad_esd;
    set_bad_esd |=> (mac_rx_q.dv && mac_rx_q.er && bad_esd_q && !rx_in_q);
  endproperty
  a_bad_esd: assert property (p_bad_esd) else $error("early end not flagged");
  property p_soi;
    (!spd100 && tx_line_en && tx_en_q && !mac_tx_en && !jab_q) ##1 !mac_tx_en[*5]
      |-> ($past(soi_q, 4) && soi_q) ##1 !soi_q;
  endproperty
  a_soi: assert property (p_soi) else $error("start of idle pulse wrong");
  property p_halt_quiet;
    (an_state_q == AN_HALT) ##1 (an_state_q == AN_HALT) |-> (!nlp_q && !flp_q && !tx_line_en);
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("pulse during quiet period");
  property p_start;
    an_start |=> (an_state_q == AN_HALT && !done_q);
  endproperty
  a_start: assert property (p_start) else $error("negotiation not restarted");
  property p_an_off;
    !an_en |=> (an_state_q == AN_OFF && !done_q);
  endproperty
  a_an_off: assert property (p_an_off) else $error("negotiation active while disabled");
  property p_done;
    $rose(done_q) |-> (an_state_q == AN_DONE && $past(an_state_q) == AN_DETECT);
  endproperty
  a_done: assert property (p_done) else $error("done without completion");
  property p_jab;
    jab_q && jab_act |=> (!tx10_q && jab_st_q && mac_col);
  endproperty
  a_jab: assert property (p_jab) else $error("jabber not enforced");
  property p_link_dis;
    link_dis |=> link_q;
  endproperty
  a_link_dis: assert property (p_link_dis) else $error("link disable not forcing pass");
endmodule : pel_phy_link

// ===== pel_pkg.sv
package pel_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int CLK_PER_MS  = CLK_HZ / 1000;
  localparam int CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam int TMR_W       = 25;
  localparam int HALT_MS     = 1200;
  localparam int HALT_CYC    = HALT_MS * CLK_PER_MS;
  localparam int PULSE_MS    = 16;
  localparam int PULSE_CYC   = PULSE_MS * CLK_PER_MS;
  localparam int LOSS_MS     = 50;
  localparam int LOSS_CYC    = LOSS_MS * CLK_PER_MS;
  localparam int JABBER_MS   = 20;
  localparam int JABBER_CYC  = JABBER_MS * CLK_PER_MS;
  localparam int SOI_NS      = 250;
  localparam int SOI_CYC     = (SOI_NS * CLK_PER_US + 999) / 1000;
  localparam int RX_SOI_NS   = 200;
  localparam int RX_SOI_CYC  = (RX_SOI_NS * CLK_PER_US + 999) / 1000;
  localparam int LINK_PULSES = 3;

  // ==========================================================
  // Register map
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_ADV    = 4'h4;
  localparam logic [3:0]  OFS_REMOTE = 4'h8;
  localparam logic [3:0]  OFS_STAT   = 4'hc;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADV_RESET  = 16'h01e1;
  localparam int CB_MAC_NEG  = 0;
  localparam int CB_PHY_NEG  = 1;
  localparam int CB_RESTART  = 2;
  localparam int CB_MAC_SPD  = 3;
  localparam int CB_MAC_DUP  = 4;
  localparam int CB_PHY_SPD  = 5;
  localparam int CB_PHY_DUP  = 6;
  localparam int CB_LINK_DIS = 7;
  localparam int CB_JAB_DIS  = 8;
  localparam int AB_10H      = 5;
  localparam int AB_10F      = 6;
  localparam int AB_100H     = 7;
  localparam int AB_100F     = 8;
  localparam int SB_LINK     = 0;
  localparam int SB_SPEED    = 1;
  localparam int SB_DUPLEX   = 2;
  localparam int SB_DONE     = 3;
  localparam int SB_BAD_ESD  = 4;
  localparam int SB_JABBER   = 5;
  localparam int SB_JAB_NOW  = 6;
  localparam int STAT_W      = 7;

  // ==========================================================
  // Code groups
  localparam logic [4:0] SYM_I = 5'h1f;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;

  typedef enum logic [3:0] {
    AN_OFF    = 4'b0001,
    AN_HALT   = 4'b0010,
    AN_DETECT = 4'b0100,
    AN_DONE   = 4'b1000
  } pel_an_state_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } pel_av_req_type;

  typedef struct packed {
    logic [3:0] rxd;
    logic       dv;
    logic       er;
  } pel_mii_rx_type;

endpackage : pel_pkg

// ===== pel_timer.sv
`timescale 1ns/10ps
// One-shot down counter; expired pulses LOAD cycles after start
module pel_timer #(
  parameter int W    = pel_pkg::TMR_W,
  parameter int LOAD = 1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic start,
  output logic      running,
  output logic      expired
);
  logic [W-1:0] cnt_q;
  logic         run_q;
  logic         exp_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (ce) begin
      exp_q <= 1'b0;
      if (start) begin
        cnt_q <= W'(LOAD - 1);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign running = run_q;
  assign expired = exp_q;
endmodule : pel_timer

// ===== pel_partner.sv
`timescale 1ns/10ps
// ==========================================================
// Remote partner: answers each burst with its own word
module pel_partner #(
  parameter logic [15:0] WORD = 16'h01e1
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   fast_link_pulse_burst,
  output logic        rx_flp_valid,
  output logic [15:0] rx_flp_word
);
  logic [2:0] dly_q;
  // Burst decode takes a few cycles on a real line
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[1:0], fast_link_pulse_burst};
    end
  end
  assign rx_flp_valid = dly_q[2];
  // Word is garbage outside the valid cycle
  assign rx_flp_word = rx_flp_valid ? WORD : ~WORD;
endmodule : pel_partner

// ===== pel_phy_link_tb_top.sv
`timescale 1ns/10ps
module pel_phy_link_tb_top;
  import pel_pkg::*;
  logic clk = 0, sys_rst = 1, ce = 1, mac_tx_en = 0, rx_sym_valid = 0, rx_stream_start = 0;
  logic rx10_active = 0, rx10_transition = 0, rx_nlp = 0, squelch_ok = 0, descr_locked = 0;
  logic [3:0] mac_txd = '0;
  logic [4:0] rx_sym = '0, tx_sym;
  logic [31:0] av_readdata, q;
  logic [15:0] flp_tx_word, rx_flp_word;
  logic av_waitrequest, tx10_en, tx_line_en, start_of_idle_pulse, normal_link_pulse;
  logic fast_link_pulse_burst, mac_col, link_pass, speed_100, full_duplex, rx_flp_valid;
  pel_av_req_type av = '0;
  pel_mii_rx_type mac_rx;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [4:0] txe[4] = '{5'h0b, SYM_T, SYM_R, SYM_I};
  logic [4:0] rxs[2][5] = '{'{SYM_I, 5'h0b, 5'h0b, SYM_T, SYM_R}, '{SYM_I, 5'h0b, 5'h0b, SYM_I, SYM_I}};

  pel_phy_link #(.HALT_CYCLES(50), .PULSE_CYCLES(20), .LOSS_CYCLES(200), .JABBER_CYCLES(30)) i_dut (
    .clk, .sys_rst, .ce, .av, .av_readdata, .av_waitrequest, .mac_tx_en, .mac_txd, .tx_sym,
    .tx10_en, .tx_line_en, .start_of_idle_pulse, .normal_link_pulse, .fast_link_pulse_burst,
    .flp_tx_word, .mac_col, .rx_sym, .rx_sym_valid, .rx_stream_start, .rx10_active,
    .rx10_transition, .rx_nlp, .rx_flp_valid, .rx_flp_word, .squelch_ok, .descr_locked,
    .mac_rx, .link_pass, .speed_100, .full_duplex);

  pel_partner i_partner (.clk, .sys_rst, .fast_link_pulse_burst, .rx_flp_valid, .rx_flp_word);

  always #25 clk = ~clk;

  // ==========================================================
  // Checking and bus access
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    av <= '{rd, !rd, a, d};
    do begin
      @(posedge clk);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av <= '0;
  endtask : bus

  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
  endtask : wait_for

  task rx_frame(input int f);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rx_stream_start <= (i == 0);
      rx_sym_valid <= (i > 0);
      rx_sym <= rxs[f][i];
    end
  endtask : rx_frame

  task print_verdict;
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      print_verdict;
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    bus(1, OFS_ADV, 0);
    chk(q, {16'h0, ADV_RESET});
    bus(0, OFS_CTRL, 32'h18);
    repeat (2) @(negedge clk);
    chk(32'({speed_100, full_duplex}), 32'h3);
    @(posedge clk);
    mac_tx_en <= 1;
    mac_txd <= 4'h5;
    @(posedge clk);
    mac_tx_en <= 0;
    foreach (txe[i]) begin
      @(negedge clk);
      chk(32'(tx_sym), 32'(txe[i]));
    end
    rx_frame(0);
    @(negedge clk);
    chk(32'({mac_rx.dv, mac_rx.er, mac_rx.rxd}), 32'h25);
    @(negedge clk);
    chk(32'({mac_rx.dv, mac_rx.er}), 32'h0);
    rx_frame(1);
    for (int i = 0; i < 10 && mac_rx.er !== 1'b1; i++) @(negedge clk);
    chk(32'({mac_rx.er, mac_rx.rxd}), 32'h10);
    @(posedge clk);
    rx_sym_valid <= 0;
    bus(1, OFS_STAT, 0);
    chk(32'(q[SB_BAD_ESD]), 32'h1);
    bus(0, OFS_STAT, 32'h10);
    bus(1, OFS_STAT, 0);
    chk(32'(q[SB_BAD_ESD]), 32'h0);
    bus(0, OFS_CTRL, 0);
    @(posedge clk);
    mac_tx_en <= 1;
    @(posedge clk);
    mac_tx_en <= 0;
    wait_for(start_of_idle_pulse, 1, 8);
    chk(32'(start_of_idle_pulse), 32'h1);
    repeat (5) @(negedge clk);
    chk(32'(start_of_idle_pulse), 32'h0);
    wait_for(normal_link_pulse, 1, 30);
    chk(32'(normal_link_pulse), 32'h1);
    @(posedge clk);
    mac_tx_en <= 1;
    wait_for(mac_col, 1, 40);
    // Transmit enable register lags the jabber flag by one cycle
    @(negedge clk);
    chk(32'({mac_col, tx10_en}), 32'h2);
    @(posedge clk);
    mac_tx_en <= 0;
    bus(1, OFS_STAT, 0);
    chk(32'(q[SB_JABBER]), 32'h1);
    bus(0, OFS_CTRL, 32'he0);
    repeat (2) @(negedge clk);
    chk(32'({link_pass, speed_100, full_duplex}), 32'h7);
    chk(32'(tx_sym), 32'(SYM_I));
    bus(0, OFS_CTRL, 32'h3);
    wait_for(tx_line_en, 0, 5);
    chk(32'(tx_line_en), 32'h0);
    // Line stays quiet until resolution, else parallel detect would win
    wait_for(speed_100, 1, 300);
    @(posedge clk);
    squelch_ok <= 1;
    descr_locked <= 1;
    wait_for(link_pass, 1, 10);
    chk(32'({link_pass, speed_100, full_duplex}), 32'h7);
    bus(1, OFS_STAT, 0);
    chk(32'(q[3:0]), 32'hf);
    bus(1, OFS_REMOTE, 0);
    chk(32'(q[15:0]), 32'h01e1);
    chk(32'(flp_tx_word), 32'(ADV_RESET));
    print_verdict;
  end
endmodule : pel_phy_link_tb_top
